// ### hw/acr_bank.sv
`timescale 1ns/100ps
`default_nettype none
module acr_bank
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic pdwn_pin,
  input wire logic pll_locked_pin,
  output logic stabilizer_on,
  output logic [2:0] divide_ratio,
  output logic [2:0] divide_phase,
  output logic [3:0] clock_divisor,
  output logic [1:0] power_state_a,
  output logic [1:0] power_state_b,
  output logic test_enable_a,
  output logic test_enable_b,
  output logic [3:0] test_select_a,
  output logic [3:0] test_select_b,
  output logic user_once_a,
  output logic user_once_b,
  output logic pn_long_reset_a,
  output logic pn_long_reset_b,
  output logic pn_short_reset_a,
  output logic pn_short_reset_b
);
  import acr_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pdwn_sr;
  logic [2:0] lock_sr;
  logic pdwn_sync;
  logic pll_locked;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pdwn_sr <= 3'h0;
      lock_sr <= 3'h0;
    end else begin
      pdwn_sr <= {pdwn_sr[1:0], pdwn_pin};
      lock_sr <= {lock_sr[1:0], pll_locked_pin};
    end
  end

  // Change counts only when stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pdwn_sync <= 1'b0;
      pll_locked <= 1'b0;
    end else begin
      if (pdwn_sr[1] == pdwn_sr[2]) begin
        pdwn_sync <= pdwn_sr[2];
      end
      if (lock_sr[1] == lock_sr[2]) begin
        pll_locked <= lock_sr[2];
      end
    end
  end

  // ----------------------------------------
  // Global staged registers
  // ----------------------------------------
  logic [7:0] index_reg;
  logic [7:0] clock_stage;
  logic [7:0] divide_stage;
  logic [7:0] clock_active;
  logic [7:0] divide_active;
  logic commit_req;
  logic commit;
  acr_commit_type state;
  logic wr_a;
  logic wr_b;

  assign wr_a = wr_en && index_reg[0];
  assign wr_b = wr_en && index_reg[1];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      index_reg <= ACR_RST_INDEX;
      clock_stage <= ACR_RST_CLOCK;
      divide_stage <= ACR_RST_DIVIDE;
    end else if (wr_en) begin
      case (addr)
        ACR_OFS_INDEX: index_reg <= wdata & ACR_MASK_INDEX;
        ACR_OFS_CLOCK: clock_stage <= wdata & ACR_MASK_CLOCK;
        ACR_OFS_DIVIDE: divide_stage <= wdata & ACR_MASK_DIVIDE;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  // Request set wins over the self-clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      commit_req <= 1'b0;
    end else if (wr_en && addr == ACR_OFS_COMMIT &&
                 wdata[ACR_POS_COMMIT]) begin
      commit_req <= 1'b1;
    end else if (state == ACR_ST_DONE) begin
      commit_req <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ACR_ST_IDLE;
    end else begin
      case (state)
        ACR_ST_IDLE: begin
          if (commit_req) begin
            state <= ACR_ST_COPY;
          end
        end
        ACR_ST_COPY: state <= ACR_ST_DONE;
        ACR_ST_DONE: state <= ACR_ST_IDLE;
        default: state <= ACR_ST_IDLE;
      endcase
    end
  end

  assign commit = state == ACR_ST_COPY;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_active <= ACR_RST_CLOCK;
      divide_active <= ACR_RST_DIVIDE;
    end else if (commit) begin
      clock_active <= clock_stage;
      divide_active <= divide_stage;
    end
  end

  // ----------------------------------------
  // Clock controls
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stabilizer_on <= 1'b1;
      divide_ratio <= 3'h0;
      divide_phase <= 3'h0;
      clock_divisor <= 4'h1;
    end else begin
      stabilizer_on <= clock_active[ACR_POS_STAB] ||
                       (divide_active[2:0] != 3'h0);
      divide_ratio <= divide_active[2:0];
      clock_divisor <= {1'b0, divide_active[2:0]} + 4'h1;
      divide_phase <= divide_active[5:3];
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  logic [7:0] pwr_stg_a, pwr_stg_b, tst_stg_a, tst_stg_b;
  logic [7:0] pwr_act_a, pwr_act_b, tst_act_a, tst_act_b;

  acr_channel u_chan_a (
    .clk(clk), .resetn(resetn), .stage_wr(wr_a), .stage_addr(addr),
    .stage_data(wdata), .commit(commit), .pdwn_sync(pdwn_sync),
    .power_stage(pwr_stg_a), .test_stage(tst_stg_a),
    .power_active(pwr_act_a), .test_active(tst_act_a),
    .power_state(power_state_a), .test_enable(test_enable_a),
    .test_select(test_select_a), .user_once(user_once_a),
    .pn_long_reset(pn_long_reset_a), .pn_short_reset(pn_short_reset_a)
  );

  acr_channel u_chan_b (
    .clk(clk), .resetn(resetn), .stage_wr(wr_b), .stage_addr(addr),
    .stage_data(wdata), .commit(commit), .pdwn_sync(pdwn_sync),
    .power_stage(pwr_stg_b), .test_stage(tst_stg_b),
    .power_active(pwr_act_b), .test_active(tst_act_b),
    .power_state(power_state_b), .test_enable(test_enable_b),
    .test_select(test_select_b), .user_once(user_once_b),
    .pn_long_reset(pn_long_reset_b), .pn_short_reset(pn_short_reset_b)
  );

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  // Local registers read from the lowest selected channel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_en;
      if (rd_en) begin
        case (addr)
          ACR_OFS_INDEX: rdata <= index_reg;
          ACR_OFS_POWER: rdata <= index_reg[0] ? pwr_stg_a : pwr_stg_b;
          ACR_OFS_CLOCK: rdata <= clock_stage;
          ACR_OFS_PLL: rdata <= {pll_locked, 7'h00};
          ACR_OFS_DIVIDE: rdata <= divide_stage;
          ACR_OFS_TEST: rdata <= index_reg[0] ? tst_stg_a : tst_stg_b;
          ACR_OFS_COMMIT: rdata <= {7'h00, commit_req};
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_commit_write;
    wr_en && addr == ACR_OFS_COMMIT && wdata[0] && state == ACR_ST_IDLE;
  endsequence

  property p_commit_copies;
    @(posedge clk) disable iff (!resetn)
      s_commit_write ##1 commit_req ##1 commit |=>
        clock_active == $past(clock_stage);
  endproperty
  a_commit_copies: assert property (p_commit_copies)
    else $error("transfer did not copy staged clock");

  property p_self_clear;
    @(posedge clk) disable iff (!resetn)
      s_commit_write |-> ##[1:4] !commit_req;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("transfer bit did not clear");

  property p_force_stab;
    @(posedge clk) disable iff (!resetn)
      divide_active[2:0] != 3'h0 |=> stabilizer_on;
  endproperty
  a_force_stab: assert property (p_force_stab)
    else $error("stabilizer not forced by divider");

  property p_stab_bit;
    @(posedge clk) disable iff (!resetn)
      divide_active[2:0] == 3'h0 |=> stabilizer_on == $past(clock_active[0]);
  endproperty
  a_stab_bit: assert property (p_stab_bit)
    else $error("stabilizer does not follow enable");

  property p_divisor;
    @(posedge clk) disable iff (!resetn)
      ##1 clock_divisor == {1'b0, $past(divide_active[2:0])} + 4'h1;
  endproperty
  a_divisor: assert property (p_divisor)
    else $error("divisor is not ratio plus one");

  property p_phase;
    @(posedge clk) disable iff (!resetn)
      ##1 divide_phase == $past(divide_active[5:3]);
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase field not applied");

  property p_pll_ro;
    @(posedge clk) disable iff (!resetn)
      rd_en && addr == ACR_OFS_PLL |=> rdata == {$past(pll_locked), 7'h00};
  endproperty
  a_pll_ro: assert property (p_pll_ro)
    else $error("lock status readback wrong");

  property p_select;
    @(posedge clk) disable iff (!resetn)
      wr_en && addr == ACR_OFS_POWER && !index_reg[1] |=>
        $stable(pwr_stg_b);
  endproperty
  a_select: assert property (p_select)
    else $error("unselected channel was written");

  property p_pin_standby;
    @(posedge clk) disable iff (!resetn)
      pdwn_sync |=>
        (power_state_a == ACR_PWR_STANDBY) == $past(pwr_act_a[5]) &&
        (power_state_b == ACR_PWR_STANDBY) == $past(pwr_act_b[5]);
  endproperty
  a_pin_standby: assert property (p_pin_standby)
    else $error("pin did not give standby");

  property p_test_en;
    @(posedge clk) disable iff (!resetn)
      ##1 test_enable_a == ($past(tst_act_a[3:0]) != 4'h0) &&
        test_enable_b == ($past(tst_act_b[3:0]) != 4'h0);
  endproperty
  a_test_en: assert property (p_test_en)
    else $error("test substitution mismatch");
endmodule
`default_nettype wire

// ### hw/acr_pkg.sv
package acr_pkg;
  localparam logic [7:0] ACR_OFS_INDEX = 8'h05;
  localparam logic [7:0] ACR_OFS_POWER = 8'h08;
  localparam logic [7:0] ACR_OFS_CLOCK = 8'h09;
  localparam logic [7:0] ACR_OFS_PLL = 8'h0A;
  localparam logic [7:0] ACR_OFS_DIVIDE = 8'h0B;
  localparam logic [7:0] ACR_OFS_TEST = 8'h0D;
  localparam logic [7:0] ACR_OFS_COMMIT = 8'hFF;
  localparam logic [7:0] ACR_RST_INDEX = 8'h03;
  localparam logic [7:0] ACR_RST_POWER = 8'h00;
  localparam logic [7:0] ACR_RST_CLOCK = 8'h01;
  localparam logic [7:0] ACR_RST_DIVIDE = 8'h00;
  localparam logic [7:0] ACR_RST_TEST = 8'h00;
  localparam logic [7:0] ACR_MASK_INDEX = 8'h03;
  localparam logic [7:0] ACR_MASK_POWER = 8'h23;
  localparam logic [7:0] ACR_MASK_CLOCK = 8'h01;
  localparam logic [7:0] ACR_MASK_DIVIDE = 8'h3F;
  localparam logic [7:0] ACR_MASK_TEST = 8'hBF;
  localparam int ACR_POS_COMMIT = 0;
  localparam int ACR_POS_PIN_FUNC = 5;
  localparam int ACR_POS_STAB = 0;
  localparam int ACR_POS_LOCK = 7;
  localparam int ACR_POS_ONCE = 7;
  localparam int ACR_POS_PN_LONG_RST = 5;
  localparam int ACR_POS_PN_SHORT_RST = 4;
  typedef enum logic [1:0] {
    ACR_PWR_NORMAL = 2'h0,
    ACR_PWR_OFF = 2'h1,
    ACR_PWR_STANDBY = 2'h2,
    ACR_PWR_RESERVED = 2'h3
  } acr_power_type;
  typedef enum logic [3:0] {
    ACR_TM_OFF = 4'h0,
    ACR_TM_MIDSCALE = 4'h1,
    ACR_TM_POS_FS = 4'h2,
    ACR_TM_NEG_FS = 4'h3,
    ACR_TM_CHECKER = 4'h4,
    ACR_TM_PN_LONG = 4'h5,
    ACR_TM_PN_SHORT = 4'h6,
    ACR_TM_TOGGLE = 4'h7,
    ACR_TM_USER = 4'h8
  } acr_test_type;
  typedef enum logic [2:0] {
    ACR_ST_IDLE = 3'h1,
    ACR_ST_COPY = 3'h2,
    ACR_ST_DONE = 3'h4
  } acr_commit_type;
endpackage

// ### hw/acr_channel.sv
`timescale 1ns/100ps
`default_nettype none
// One converter channel: staged and active local registers
module acr_channel
  import acr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic stage_wr,
  input wire logic [7:0] stage_addr,
  input wire logic [7:0] stage_data,
  input wire logic commit,
  input wire logic pdwn_sync,
  output logic [7:0] power_stage,
  output logic [7:0] test_stage,
  output logic [7:0] power_active,
  output logic [7:0] test_active,
  output logic [1:0] power_state,
  output logic test_enable,
  output logic [3:0] test_select,
  output logic user_once,
  output logic pn_long_reset,
  output logic pn_short_reset
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_stage <= ACR_RST_POWER;
      test_stage <= ACR_RST_TEST;
    end else if (stage_wr) begin
      if (stage_addr == ACR_OFS_POWER) begin
        power_stage <= stage_data & ACR_MASK_POWER;
      end
      if (stage_addr == ACR_OFS_TEST) begin
        test_stage <= stage_data & ACR_MASK_TEST;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_active <= ACR_RST_POWER;
      test_active <= ACR_RST_TEST;
    end else if (commit) begin
      power_active <= power_stage;
      test_active <= test_stage;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_state <= ACR_PWR_NORMAL;
    end else if (pdwn_sync) begin
      power_state <= power_active[ACR_POS_PIN_FUNC] ? ACR_PWR_STANDBY
                                                     : ACR_PWR_OFF;
    end else begin
      if (power_active[1:0] == ACR_PWR_RESERVED) begin
        power_state <= ACR_PWR_NORMAL;
      end else begin
        power_state <= power_active[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      test_enable <= 1'b0;
      test_select <= ACR_TM_OFF;
      user_once <= 1'b0;
      pn_long_reset <= 1'b0;
      pn_short_reset <= 1'b0;
    end else begin
      test_enable <= test_active[3:0] != ACR_TM_OFF;
      test_select <= test_active[3:0];
      user_once <= test_active[ACR_POS_ONCE];
      pn_long_reset <= test_active[ACR_POS_PN_LONG_RST];
      pn_short_reset <= test_active[ACR_POS_PN_SHORT_RST];
    end
  end
endmodule
`default_nettype wire

// ### dv/acr_host.sv
`timescale 1ns/100ps
`default_nettype none
module acr_host
  import acr_pkg::*;
(
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  logic [7:0] exp_q[$];
  // Strobes stay up so calls can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic sel(input logic [1:0] ch);
    wr(ACR_OFS_INDEX, {6'h00, ch});
  endtask
  task automatic commit();
    wr(ACR_OFS_COMMIT, 8'h01);
    rd(ACR_OFS_COMMIT, 8'h01);
    idle(6);
    rd(ACR_OFS_COMMIT, 8'h00);
    idle(1);
  endtask
endmodule
`default_nettype wire

// ### dv/acr_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module acr_bank_tb
  import acr_pkg::*;
;
  logic clk;
  logic resetn;
  logic pdwn_pin;
  logic pll_locked_pin;
  logic wr_en, rd_en, rvalid, stabilizer_on;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] divide_ratio, divide_phase;
  logic [3:0] clock_divisor, test_select_a, test_select_b;
  logic [1:0] power_state_a, power_state_b;
  logic test_enable_a, test_enable_b, user_once_a, user_once_b;
  logic pn_long_reset_a, pn_long_reset_b;
  logic pn_short_reset_a, pn_short_reset_b;
  logic [7:0] rst_addr [8] = '{8'h05, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D,
    8'hFF, 8'h20};
  logic [7:0] rst_val [8] = '{8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};
  int fails = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h87077281;
  always #5 clk = ~clk;
  acr_bank u_acr_bank (
    .clk(clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
    .pdwn_pin(pdwn_pin), .pll_locked_pin(pll_locked_pin),
    .stabilizer_on(stabilizer_on), .divide_ratio(divide_ratio),
    .divide_phase(divide_phase), .clock_divisor(clock_divisor),
    .power_state_a(power_state_a), .power_state_b(power_state_b),
    .test_enable_a(test_enable_a), .test_enable_b(test_enable_b),
    .test_select_a(test_select_a), .test_select_b(test_select_b),
    .user_once_a(user_once_a), .user_once_b(user_once_b),
    .pn_long_reset_a(pn_long_reset_a),
    .pn_long_reset_b(pn_long_reset_b),
    .pn_short_reset_a(pn_short_reset_a),
    .pn_short_reset_b(pn_short_reset_b)
  );
  acr_host u_acr_host (
    .clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim();
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t output %h exp %h", $time, got, exp);
    end
  endtask
  // Oldest noted read result against each rvalid
  always @(posedge clk) begin
    if (resetn === 1'b1 && rvalid === 1'b1) begin
      if (u_acr_host.exp_q.size() == 0) begin
        fails++;
        $display("mismatch %0t unexpected rvalid", $time);
      end else begin
        chk_rd(rdata, u_acr_host.exp_q.pop_front());
      end
    end
  end
  initial begin : main
    logic [7:0] d;
    logic [2:0] pr;
    logic st;
    clk = 1'b0;
    resetn = 1'b0;
    pdwn_pin <= 1'b0;
    pll_locked_pin <= 1'b0;
    u_acr_host.idle(4);
    chk_out({7'h00, stabilizer_on}, 8'h01);
    chk_out({4'h0, clock_divisor}, 8'h01);
    u_acr_host.idle(4);
    resetn <= 1'b1;
    u_acr_host.idle(1);
    for (int i = 0; i < 8; i++) begin
      u_acr_host.rd(rst_addr[i], rst_val[i]);
    end
    pr = 3'h0;
    for (int r = 0; r < 8; r++) begin
      seed = lfsr(seed);
      st = seed[3];
      d = {seed[7:6], seed[2:0], 3'(r)};
      u_acr_host.wr(ACR_OFS_CLOCK, {seed[7:1], st});
      u_acr_host.wr(ACR_OFS_DIVIDE, d);
      u_acr_host.rd(ACR_OFS_CLOCK, {7'h00, st});
      u_acr_host.rd(ACR_OFS_DIVIDE, d & ACR_MASK_DIVIDE);
      u_acr_host.idle(2);
      chk_out({5'h00, divide_ratio}, {5'h00, pr});
      u_acr_host.commit();
      chk_out({5'h00, divide_ratio}, {5'h00, d[2:0]});
      chk_out({5'h00, divide_phase}, {5'h00, d[5:3]});
      chk_out({4'h0, clock_divisor}, 8'(r + 1));
      chk_out({7'h00, stabilizer_on}, {7'h00, st | (r != 0)});
      pr = d[2:0];
    end
    for (int c = 0; c < 3; c++) begin
      d = 8'((c + 1) % 3) | 8'h20;
      u_acr_host.sel(2'b01);
      u_acr_host.wr(ACR_OFS_POWER, 8'(c));
      u_acr_host.sel(2'b10);
      u_acr_host.wr(ACR_OFS_POWER, d);
      u_acr_host.rd(ACR_OFS_POWER, d);
      u_acr_host.sel(2'b01);
      u_acr_host.rd(ACR_OFS_POWER, 8'(c));
      u_acr_host.commit();
      chk_out({6'h00, power_state_a}, 8'(c));
      chk_out({6'h00, power_state_b}, d & 8'h03);
    end
    // Reserved code must give normal power state on channel A
    u_acr_host.wr(ACR_OFS_POWER, 8'h03);
    u_acr_host.commit();
    chk_out({6'h00, power_state_a}, 8'h00);
    // Channel B keeps pin function set from the last pass
    u_acr_host.wr(ACR_OFS_POWER, 8'h00);
    u_acr_host.commit();
    pdwn_pin <= 1'b1;
    u_acr_host.idle(8);
    chk_out({6'h00, power_state_a}, 8'h01);
    chk_out({6'h00, power_state_b}, 8'h02);
    pdwn_pin <= 1'b0;
    u_acr_host.idle(8);
    chk_out({6'h00, power_state_b}, 8'h00);
    u_acr_host.sel(2'b11);
    for (int c = 0; c < 9; c++) begin
      seed = lfsr(seed);
      d = {seed[7:4], 4'(c)};
      u_acr_host.wr(ACR_OFS_TEST, d);
      u_acr_host.rd(ACR_OFS_TEST, d & ACR_MASK_TEST);
      u_acr_host.commit();
      chk_out({7'h00, test_enable_a}, {7'h00, c != 0});
      chk_out({3'h0, test_enable_b, test_select_b},
        8'(c) | (8'(c != 0) << 4));
      chk_out({4'h0, test_select_a}, 8'(c));
      chk_out({5'h00, user_once_a, pn_long_reset_a, pn_short_reset_a},
        {5'h00, d[7], d[5], d[4]});
      chk_out({5'h00, user_once_b, pn_long_reset_b, pn_short_reset_b},
        {5'h00, d[7], d[5], d[4]});
    end
    u_acr_host.wr(ACR_OFS_PLL, 8'hFF);
    u_acr_host.wr(8'h20, 8'h5A);
    u_acr_host.rd(ACR_OFS_PLL, 8'h00);
    u_acr_host.rd(8'h20, 8'h00);
    // Lock level from the random stream, then its inverse
    seed = lfsr(seed);
    st = seed[5];
    for (int k = 0; k < 2; k++) begin
      pll_locked_pin <= st;
      u_acr_host.idle(8);
      u_acr_host.rd(ACR_OFS_PLL, {st, 7'h00});
      st = ~st;
    end
    u_acr_host.idle(2);
    for (int i = 0; i < 8 && u_acr_host.exp_q.size() != 0; i++) begin
      @(posedge clk);
    end
    if (u_acr_host.exp_q.size() != 0) begin
      fails++;
      $display("mismatch %0t reads left unanswered", $time);
    end
    end_sim();
  end
  initial begin : watchdog
    #500000;
    fails++;
    $display("mismatch %0t run limit reached", $time);
    end_sim();
  end
endmodule
`default_nettype wire
